// ==== imv_cpu_model.sv ====
// Bus master model of the CPU core that programs masks and reads vectors.
`timescale 1ns/1ps
`default_nettype none
module imv_cpu_model
  import imv_pkg::*;
(
  input wire logic clock,       // System clock.
  input wire logic [7:0] rdata, // Read data from the block.
  output imv_bus_t bus          // Strobes, address and data.
);
  initial bus = '0;

  // A write is one strobe cycle; the idle cycle after it avoids two
  // assignments to the bus in one time step when calls follow each other.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clock);
    bus <= '0;
    @(posedge clock);
  endtask

  // Read data stand only in the cycle after the strobe; they are taken
  // at the rising edge that ends that cycle, before the block moves on.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clock);
    bus <= '0;
    @(posedge clock);
    d = rdata;
  endtask
endmodule
`default_nettype wire

// ==== imv_ctrl.sv ====
// Interrupt enable mask, vector read and pending clear.
`timescale 1ns/1ps
`default_nettype none
`include "imv_params.svh"
module imv_ctrl
  import imv_pkg::*;
(
  input wire logic clock,       // System clock, 20 MHz.
  input wire logic rst,         // Asynchronous reset, active high.
  input wire logic ce,          // Clock enable.
  input wire imv_bus_t bus,     // Register strobes, address, data.
  output logic [7:0] rdata,     // Read data, cycle after read.
  input wire imv_src_t src_post, // Hardware post pulses.
  output logic irq,             // Interrupt level.
  output logic [7:0] posted,    // Posted flags.
  output logic [7:0] pending,   // Posted and enabled flags.
  output logic [7:0] vector,    // Vector of top pending source.
  output logic vec_valid        // Some source pending.
);

  localparam int NSRC = `IMV_NSRC;

  logic [7:0] mask_reg;
  logic [7:0] mask_next;
  logic swen_reg;
  logic swen_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic irq_reg;
  logic irq_next;

  logic wr_mask;
  logic wr_vec;
  logic wr_swctl;
  logic wr_postclr;
  logic wr_clear;
  logic [7:0] src_vec;
  logic [2:0] win_idx;
  logic [7:0] rd_swctl;
  logic [7:0] rd_val;

  assign src_vec = src_post;

  // Address decode of the write strobe.
  always_comb begin
    wr_mask = bus.wr && (bus.addr == `IMV_ADDR_MASK0);
    wr_vec = bus.wr && (bus.addr == `IMV_ADDR_VECTOR);
    wr_swctl = bus.wr && (bus.addr == `IMV_ADDR_SWCTL);
    wr_postclr = bus.wr && (bus.addr == `IMV_ADDR_POSTCLR);
    wr_clear = bus.wr && (bus.addr == `IMV_ADDR_CLEAR);
  end

  // One flag per source; the mask gates the pending side and the vector-write clear.
  for (genvar i = 0; i < NSRC; i++) begin : g_src
    imv_src_bit u_bit (
      .clock(clock),
      .rst(rst),
      .ce(ce),
      .event_in(src_vec[i]),
      .enable(mask_reg[i]),
      .sw_wr(wr_postclr),
      .sw_mode(swen_reg),
      .sw_data(bus.wdata[i]),
      .clr_one(wr_clear & bus.wdata[i]),
      .clr_pend(wr_vec), // R11
      .posted(posted[i]),
      .pending(pending[i]) // R01 R02 R03 R04 R05 R06 R07 R08 R13
    );
  end

  imv_prio #(
    .N(NSRC),
    .W(3)
  ) u_prio (
    .pend(pending), // R13
    .valid(vec_valid),
    .idx(win_idx)
  );

  // Each source owns a distinct vector; idle reads as zero.
  always_comb begin
    if (vec_valid) begin
      vector = 8'(`IMV_VEC_BASE + int'(win_idx) * `IMV_VEC_STEP); // R16
    end else begin
      vector = `IMV_VECTOR_NONE; // R15
    end
  end

  // Mask, soft enable and interrupt next values.
  always_comb begin
    mask_next = mask_reg;
    swen_next = swen_reg;
    if (wr_mask) begin
      mask_next = bus.wdata; // R09
    end
    if (wr_swctl) begin
      swen_next = bus.wdata[`IMV_BIT_SOFT_EN]; // R14
    end
    irq_next = |pending;
  end

  // Read mux; write-only and unmapped addresses read zero.
  always_comb begin
    rd_swctl = 8'h00;
    rd_swctl[`IMV_BIT_SOFT_EN] = swen_reg;
    unique case (bus.addr)
      `IMV_ADDR_MASK0: begin
        rd_val = mask_reg; // R09
      end
      `IMV_ADDR_VECTOR: begin
        rd_val = vector; // R10
      end
      `IMV_ADDR_SWCTL: begin
        rd_val = rd_swctl;
      end
      `IMV_ADDR_POSTCLR,
      `IMV_ADDR_STATUS: begin
        rd_val = posted;
      end
      default: begin
        rd_val = 8'h00;
      end
    endcase
    // Data stand only in the cycle after the read strobe.
    rdata_next = bus.rd ? rd_val : 8'h00;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mask_reg <= `IMV_MASK_RESET; // R15
      swen_reg <= `IMV_SWCTL_RESET;
      rdata_reg <= 8'h00;
      irq_reg <= 1'b0;
    end else if (ce) begin
      mask_reg <= mask_next;
      swen_reg <= swen_next;
      rdata_reg <= rdata_next;
      irq_reg <= irq_next;
    end
  end

  assign rdata = rdata_reg;
  assign irq = irq_reg;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  chk_gate_gpio1: assert property ( // R01
    pending[`IMV_BIT_GPIO1] |-> mask_reg[`IMV_BIT_GPIO1])
    else $error("GPIO port 1 pending while masked");

  chk_gate_sleep: assert property ( // R02
    pending[`IMV_BIT_SLEEP] |-> mask_reg[`IMV_BIT_SLEEP])
    else $error("sleep timer pending while masked");

  chk_gate_extb: assert property ( // R03
    pending[`IMV_BIT_EXTB] |-> mask_reg[`IMV_BIT_EXTB])
    else $error("pin b pending while masked");

  chk_gate_gpio0: assert property ( // R04
    pending[`IMV_BIT_GPIO0] |-> mask_reg[`IMV_BIT_GPIO0])
    else $error("GPIO port 0 pending while masked");

  chk_gate_spirx: assert property ( // R05
    pending[`IMV_BIT_SPIRX] |-> mask_reg[`IMV_BIT_SPIRX])
    else $error("SPI receive pending while masked");

  chk_gate_spitx: assert property ( // R06
    pending[`IMV_BIT_SPITX] |-> mask_reg[`IMV_BIT_SPITX])
    else $error("SPI transmit pending while masked");

  chk_gate_exta: assert property ( // R07
    pending[`IMV_BIT_EXTA] |-> mask_reg[`IMV_BIT_EXTA])
    else $error("pin a pending while masked");

  chk_gate_porlvd: assert property ( // R08
    pending[`IMV_BIT_PORLVD] |-> mask_reg[`IMV_BIT_PORLVD])
    else $error("power-on source pending while masked");

  chk_mask_readback: assert property ( // R09
    ce && wr_mask ##1 ce && bus.rd
    && bus.addr == `IMV_ADDR_MASK0
    |=> rdata == $past(bus.wdata, 2))
    else $error("mask did not read back as written");

  chk_vec_read: assert property ( // R10
    ce && bus.rd && bus.addr == `IMV_ADDR_VECTOR
    |=> rdata == $past(vector))
    else $error("vector read wrong");

  chk_vec_clear: assert property ( // R11
    ce && wr_vec && src_vec == 8'h00 |=> pending == 8'h00)
    else $error("vector write left a request pending");

  chk_idle_vector: assert property ( // R15
    pending == 8'h00 |-> vector == `IMV_VECTOR_NONE && !vec_valid)
    else $error("idle vector not zero");

  chk_irq_level: assert property (
    ce && |pending ##1 ce |-> irq)
    else $error("interrupt not raised");

  chk_read_once: assert property (
    ce && !bus.rd |=> rdata == 8'h00)
    else $error("read data outside its cycle");

  // Pending is the posted flag gated by its mask bit and nothing else.
  chk_pend_gate: assert property ( // R13
    pending == (posted & mask_reg))
    else $error("pending differs from posted and mask");

  chk_valid_any: assert property ( // R13
    vec_valid == (pending != 8'h00))
    else $error("valid flag differs from pending");

  // The encoder has no clock, so its order is checked here on ours.
  chk_prio_lowest: assert property ( // R16
    pending[`IMV_BIT_PORLVD] |-> vec_valid
    && vector == 8'(`IMV_VEC_BASE))
    else $error("lowest source did not win");

  chk_vec_exta: assert property ( // R16
    pending[1:0] == 2'h2
    |-> vector == 8'(`IMV_VEC_BASE + `IMV_VEC_STEP))
    else $error("pin a vector wrong");

  chk_vec_spitx: assert property ( // R16
    pending[2:0] == 3'h4
    |-> vector == 8'(`IMV_VEC_BASE + 2 * `IMV_VEC_STEP))
    else $error("SPI transmit vector wrong");

  chk_vec_spirx: assert property ( // R16
    pending[3:0] == 4'h8
    |-> vector == 8'(`IMV_VEC_BASE + 3 * `IMV_VEC_STEP))
    else $error("SPI receive vector wrong");

  chk_vec_gpio0: assert property ( // R16
    pending[4:0] == 5'h10
    |-> vector == 8'(`IMV_VEC_BASE + 4 * `IMV_VEC_STEP))
    else $error("GPIO port 0 vector wrong");

  chk_vec_extb: assert property ( // R16
    pending[5:0] == 6'h20
    |-> vector == 8'(`IMV_VEC_BASE + 5 * `IMV_VEC_STEP))
    else $error("pin b vector wrong");

  chk_vec_sleep: assert property ( // R16
    pending[6:0] == 7'h40
    |-> vector == 8'(`IMV_VEC_BASE + 6 * `IMV_VEC_STEP))
    else $error("sleep timer vector wrong");

  chk_vec_gpio1: assert property ( // R16
    pending == 8'h80
    |-> vector == 8'(`IMV_VEC_BASE + 7 * `IMV_VEC_STEP))
    else $error("GPIO port 1 vector wrong");

  // Mask bits change only on a write to their own address.
  chk_mask_write: assert property ( // R09
    ce && wr_mask |=> mask_reg == $past(bus.wdata))
    else $error("mask write not taken");

  chk_mask_hold: assert property ( // R09
    !(ce && wr_mask) |=> mask_reg == $past(mask_reg))
    else $error("mask changed without a write");

  chk_swen_write: assert property ( // R14
    ce && wr_swctl |=> swen_reg == $past(bus.wdata[`IMV_BIT_SOFT_EN]))
    else $error("soft enable write not taken");

  chk_soft_post: assert property ( // R14
    ce && wr_postclr && swen_reg
    |=> (posted & $past(bus.wdata)) == $past(bus.wdata))
    else $error("soft post did not set its flags");

  chk_clear_reg: assert property (
    ce && wr_clear && src_vec == 8'h00
    |=> (posted & $past(bus.wdata)) == 8'h00)
    else $error("clear register left a flag set");

  // Masked flags survive a vector write so they can be served later.
  chk_vec_keep: assert property ( // R11
    ce && wr_vec && src_vec == 8'h00
    |=> posted == ($past(posted) & ~$past(mask_reg)))
    else $error("vector write touched a masked flag");

  chk_status_read: assert property (
    ce && bus.rd && bus.addr == `IMV_ADDR_STATUS
    |=> rdata == $past(posted))
    else $error("status read wrong");

  // A low enable must hold every register, whatever the strobes do.
  chk_freeze_mask: assert property (
    !ce |=> mask_reg == $past(mask_reg) && swen_reg == $past(swen_reg))
    else $error("mask or soft enable moved while frozen");

  chk_freeze_posted: assert property (
    !ce |=> posted == $past(posted))
    else $error("posted flags moved while frozen");

  chk_freeze_out: assert property (
    !ce |=> rdata == $past(rdata) && irq == $past(irq))
    else $error("outputs moved while frozen");

  chk_irq_low: assert property (
    ce && pending == 8'h00 ##1 ce |-> !irq)
    else $error("interrupt raised with nothing pending");

endmodule
`default_nettype wire

// ==== imv_params.svh ====
// Constants for the interrupt mask and vector block.
// How it works
// (R01) Mask bit 7 lets the GPIO port 1 request become pending.
// (R02) Mask bit 6 lets the sleep timer request become pending.
// (R03) Mask bit 5 lets external pin b request become pending.
// (R04) Mask bit 4 lets the GPIO port 0 request become pending.
// (R05) Mask bit 3 lets the SPI receive request become pending.
// (R06) Mask bit 2 lets the SPI transmit request become pending.
// (R07) Mask bit 1 lets external pin a request become pending.
// (R08) Mask bit 0 lets the power-on/low-voltage request become pending.
// (R09) Mask bit 0 masks, 1 unmasks; all mask bits read and write.
// (R10) Reading the vector register returns the top pending vector.
// (R11) Any write to the vector register clears all pending requests.
// (R12) A masked source still posts; the mask only blocks pending.
// (R13) Only posted and enabled requests feed the priority encoder.
// (R14) Soft enable clear: zeros clear, ones ignored; set: ones post.
// (R15) Reset leaves masks zero, nothing pending; idle vector reads zero.
// (R16) Fixed priority, each source has its own constant vector.
`ifndef IMV_PARAMS_SVH
`define IMV_PARAMS_SVH

`define IMV_NSRC 8
`define IMV_ADDR_MASK0 8'he0
`define IMV_ADDR_VECTOR 8'he2
`define IMV_ADDR_SWCTL 8'he3
`define IMV_ADDR_POSTCLR 8'he4
`define IMV_ADDR_STATUS 8'he5
`define IMV_ADDR_CLEAR 8'he6

`define IMV_BIT_GPIO1 7
`define IMV_BIT_SLEEP 6
`define IMV_BIT_EXTB 5
`define IMV_BIT_GPIO0 4
`define IMV_BIT_SPIRX 3
`define IMV_BIT_SPITX 2
`define IMV_BIT_EXTA 1
`define IMV_BIT_PORLVD 0
`define IMV_BIT_SOFT_EN 7

`define IMV_MASK_RESET 8'h00
`define IMV_SWCTL_RESET 1'b0
`define IMV_POSTED_RESET 1'b0
`define IMV_VECTOR_NONE 8'h00
`define IMV_VEC_BASE 4
`define IMV_VEC_STEP 4

`endif

// ==== imv_pkg.sv ====
// Types shared by the interrupt mask and vector block.
package imv_pkg;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } imv_bus_t;

  typedef struct packed {
    logic gpio1;
    logic sleep_timer;
    logic ext_irq_pin_b;
    logic gpio0;
    logic spi_rx;
    logic spi_tx;
    logic ext_irq_pin_a;
    logic power_on_low_voltage_detect;
  } imv_src_t;

endpackage

// ==== imv_prio.sv ====
// Fixed-priority encoder over the pending requests.
`timescale 1ns/1ps
`default_nettype none
module imv_prio #(
  parameter int N = 8, // Number of sources.
  parameter int W = 3  // Index width.
) (
  input wire logic [N-1:0] pend, // Pending requests.
  output logic valid,            // Any request pending.
  output logic [W-1:0] idx       // Winning source.
);

  // Lowest index wins, so the power-on source is served first.
  always_comb begin
    valid = 1'b0;
    idx = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (pend[i]) begin
        valid = 1'b1; // R16
        idx = W'(i);
      end
    end
  end

endmodule
`default_nettype wire

// ==== imv_src_bit.sv ====
// One posted-request flag with its enable gate.
`timescale 1ns/1ps
`default_nettype none
`include "imv_params.svh"
module imv_src_bit (
  input wire logic clock,    // System clock.
  input wire logic rst,      // Asynchronous reset, active high.
  input wire logic ce,       // Clock enable.
  input wire logic event_in, // Hardware post request.
  input wire logic enable,   // Mask bit for this source.
  input wire logic sw_wr,    // Write to the post/clear register.
  input wire logic sw_mode,  // Soft interrupt enable.
  input wire logic sw_data,  // Written bit for this source.
  input wire logic clr_one,  // Clear register bit written as one.
  input wire logic clr_pend, // Vector register written.
  output logic posted,       // Posted flag.
  output logic pending       // Posted and enabled.
);

  logic posted_reg;
  logic posted_next;
  logic set_req;
  logic clr_req;

  always_comb begin
    set_req = event_in | (sw_wr & sw_mode & sw_data); // R12 R14
    clr_req = (sw_wr & ~sw_mode & ~sw_data) | clr_one // R14
      | (clr_pend & enable); // R11
    // A post in the cycle of a clear must not be lost.
    if (set_req) begin
      posted_next = 1'b1;
    end else if (clr_req) begin
      posted_next = 1'b0;
    end else begin
      posted_next = posted_reg;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      posted_reg <= `IMV_POSTED_RESET; // R15
    end else if (ce) begin
      posted_reg <= posted_next;
    end
  end

  assign posted = posted_reg;
  assign pending = posted_reg & enable; // R13

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  chk_post_masked: assert property ( // R12
    ce && event_in |=> posted_reg)
    else $error("hardware post lost");

  chk_soft_ones_void: assert property ( // R14
    ce && sw_wr && !sw_mode && sw_data && !event_in
    && !clr_one && !clr_pend |=> posted_reg == $past(posted_reg))
    else $error("one written with soft disable changed flag");

  chk_soft_zero_clr: assert property ( // R14
    ce && sw_wr && !sw_mode && !sw_data && !event_in
    |=> !posted_reg)
    else $error("zero written with soft disable did not clear");

endmodule
`default_nettype wire

// ==== imv_top_unused_placeholder_never.sv ====
// Intentionally empty.
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ==== tb_imv_ctrl.sv ====
// Self-checking testbench for the interrupt mask and vector block.
`timescale 1ns/1ps
`default_nettype none
module tb_imv_ctrl;
  import imv_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  imv_src_t src_post = '0;
  imv_bus_t bus;
  logic [7:0] rdata, posted, pending, vector, d;
  logic irq, vec_valid;
  logic [15:0] lf = 16'h89b5;
  logic [7:0] m_mask = 8'h00;
  logic [7:0] m_post = 8'h00;
  int n_mismatch = 0;
  int n_tests = 0;

  always #25 clock = ~clock;

  imv_ctrl i_imv_ctrl (.clock(clock), .rst(rst), .ce(ce), .bus(bus),
    .rdata(rdata), .src_post(src_post), .irq(irq), .posted(posted),
    .pending(pending), .vector(vector), .vec_valid(vec_valid));
  imv_cpu_model i_imv_cpu_model (.clock(clock), .rdata(rdata), .bus(bus));

  function logic [7:0] rnd();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return lf[7:0];
  endfunction

  // The lowest source index wins.
  function automatic logic [7:0] exp_vec(input logic [7:0] p);
    exp_vec = 8'h00;
    for (int i = 7; i >= 0; i--) if (p[i]) exp_vec = 8'(4 + 4 * i);
  endfunction

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("Counts: tests=%0d mismatches=%0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic post(input logic [7:0] v);
    src_post <= imv_src_t'(v);
    @(posedge clock);
    src_post <= '0;
    m_post = m_post | v;
    @(posedge clock);
  endtask

  task automatic check();
    logic [7:0] p;
    p = m_post & m_mask;
    @(posedge clock);
    @(negedge clock);
    cmp(posted, m_post);
    cmp(pending, p);
    cmp({7'h00, irq}, {7'h00, |p});
    cmp({7'h00, vec_valid}, {7'h00, |p});
    @(posedge clock);
    i_imv_cpu_model.rd(8'he2, d);
    cmp(d, exp_vec(p));
  endtask

  initial begin
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    i_imv_cpu_model.rd(8'he0, d);
    cmp(d, 8'h00);
    check();
    for (int i = 0; i < 8; i++) begin
      m_mask = rnd() & ~(8'h01 << i);
      i_imv_cpu_model.wr(8'he0, m_mask);
      post(rnd() | (8'h01 << i));
      check();
      m_mask = m_mask | (8'h01 << i);
      i_imv_cpu_model.wr(8'he0, m_mask);
      i_imv_cpu_model.rd(8'he0, d);
      cmp(d, m_mask);
      check();
      i_imv_cpu_model.wr(8'he2, rnd());
      m_post = m_post & ~m_mask;
      check();
    end
    // Software posting and clearing through the post/clear register.
    i_imv_cpu_model.wr(8'he3, 8'h80);
    i_imv_cpu_model.rd(8'he3, d);
    cmp(d, 8'h80);
    d = rnd();
    i_imv_cpu_model.wr(8'he4, d);
    m_post = m_post | d;
    check();
    i_imv_cpu_model.wr(8'he4, 8'h00);
    check();
    i_imv_cpu_model.wr(8'he3, 8'h00);
    i_imv_cpu_model.wr(8'he4, 8'hff);
    check();
    d = rnd();
    i_imv_cpu_model.wr(8'he4, d);
    m_post = m_post & d;
    check();
    m_mask = 8'hff;
    i_imv_cpu_model.wr(8'he0, m_mask);
    post(8'hff);
    check();
    d = rnd();
    i_imv_cpu_model.wr(8'he6, d);
    m_post = m_post & ~d;
    check();
    i_imv_cpu_model.rd(8'he5, d);
    cmp(d, m_post);
    i_imv_cpu_model.wr(8'he2, 8'h00);
    m_post = 8'h00;
    check();
    // A low clock enable must ignore posts and register writes alike.
    ce <= 1'b0;
    src_post <= '1;
    @(posedge clock);
    src_post <= '0;
    i_imv_cpu_model.wr(8'he0, 8'h00);
    ce <= 1'b1;
    check();
    i_imv_cpu_model.rd(8'he0, d);
    cmp(d, m_mask);
    // Reset in mid-run with requests pending.
    post(8'h5a);
    rst <= 1'b1;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    m_mask = 8'h00;
    m_post = 8'h00;
    i_imv_cpu_model.rd(8'he0, d);
    cmp(d, m_mask);
    check();
    end_sim();
  end

  initial begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    end_sim();
  end
endmodule
`default_nettype wire
